// >>> testbench/ddr_read_capture_sync_tb.sv
// Self-checking bench for ddrrc_top with a behavioural memory.
// Assumes ref_clk 200 MHz and a strobe of 80 ns period within reads.
`timescale 1ns/1ps
`default_nettype none
module ddr_read_capture_sync_tb;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        ddr_mode = 1'b1;
    logic        read_en = 1'b0;
    logic [5:0]  dll_cal = 6'h04;
    wire  [15:0] dq_pin, rd_data_rise, rd_data_fall;
    wire  [1:0]  strobe_pin, read_data_valid_flag, sync_clock_polarity;
    wire  [1:0]  read_strobe_shifted, write_strobe_shifted;
    int          fails = 0;
    int          tests_run = 0;
    int          cycles = 0;
    logic [15:0] exp_r[2][$], exp_f[2][$], qr[$], qf[$];

    initial forever #2.5 ref_clk = ~ref_clk;

    ddrrc_top i_ddrrc_top (.ref_clk(ref_clk), .reset_n(reset_n),
        .ddr_mode(ddr_mode), .read_en(read_en), .dq_pin(dq_pin),
        .strobe_pin(strobe_pin), .dll_cal(dll_cal),
        .rd_data_rise(rd_data_rise), .rd_data_fall(rd_data_fall),
        .read_data_valid_flag(read_data_valid_flag),
        .sync_clock_polarity(sync_clock_polarity),
        .read_strobe_shifted(read_strobe_shifted),
        .write_strobe_shifted(write_strobe_shifted));
    ddrrc_mem_model i_mem (.strobe(strobe_pin), .dq(dq_pin));

    ////////////////////////////////////////////////////////////////////////
    // Compares one value and counts it.
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        tests_run++;
        if (seen !== want) begin
            fails++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // One read of n beat pairs; only an armed DDR read yields pairs.
    task automatic do_read(input int n, input logic arm);
        qr.delete();
        qf.delete();
        repeat (n) begin
            qr.push_back(16'($urandom));
            qf.push_back(16'($urandom));
        end
        for (int g = 0; g < 2 && arm && ddr_mode; g++) begin
            foreach (qr[i]) exp_r[g].push_back(qr[i]);
            foreach (qf[i]) exp_f[g].push_back(qf[i]);
        end
        @(posedge ref_clk);
        #1 read_en = arm;
        repeat ($urandom_range(3, 12)) @(posedge ref_clk);
        #($urandom_range(0, 49) / 10.0);
        i_mem.burst(qr, qf);
        repeat (30) @(posedge ref_clk);
        #1 read_en = 1'b0;
        check(16'(exp_r[0].size() + exp_r[1].size()), 16'h0);
    endtask

    // Each valid pulse must carry the oldest queued pair of its group.
    always @(negedge ref_clk) begin
        for (int g = 0; g < 2; g++) begin
            if (read_data_valid_flag[g] === 1'b1 && exp_r[g].size() == 0) begin
                check(16'h1, 16'h0);
            end else if (read_data_valid_flag[g] === 1'b1) begin
                check(rd_data_rise[g*8+:8], exp_r[g][0][g*8+:8]);
                check(rd_data_fall[g*8+:8], exp_f[g][0][g*8+:8]);
                void'(exp_r[g].pop_front());
                void'(exp_f[g].pop_front());
            end
        end
    end

    // Cuts a hang short.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [1:0] pol;
        void'($urandom(32'h911f));
        repeat (6) @(posedge ref_clk);
        check({read_data_valid_flag, sync_clock_polarity}, 16'h0);
        #1 reset_n = 1'b1;
        $display("test reset done");
        for (int k = 0; k < 6; k++) do_read($urandom_range(1, 4), 1'b1);
        pol = sync_clock_polarity;
        repeat (20) @(posedge ref_clk);
        check(sync_clock_polarity, pol);
        $display("test ddr reads done");
        do_read(2, 1'b0);
        $display("test unarmed strobe done");
        @(posedge ref_clk);
        #1 ddr_mode = 1'b0;
        i_mem.hold_word(16'hc3a5);
        repeat (6) @(posedge ref_clk);
        check(rd_data_rise, 16'hc3a5);
        do_read(2, 1'b1);
        @(posedge ref_clk);
        #1 ddr_mode = 1'b1;
        $display("test plain mode done");
        reset_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        check({read_data_valid_flag, sync_clock_polarity}, 16'h0);
        #1 reset_n = 1'b1;
        repeat (3) do_read(3, 1'b1);
        $display("test second reset done");
        wrap_up();
    end
endmodule // ddr_read_capture_sync_tb
`default_nettype wire

// >>> testbench/ddrrc_assertions.sv
// Port checker for the DDR read capture block, bound to ddrrc_top.
// Assumes dll_cal is held at 6'h04 by the bench.
`timescale 1ns/1ps
`default_nettype none
module ddrrc_checker (
    input wire logic        ref_clk,
    input wire logic        reset_n,
    input wire logic        ddr_mode,
    input wire logic        read_en,
    input wire logic [5:0]  dll_cal,
    input wire logic [15:0] rd_data_rise,
    input wire logic [15:0] rd_data_fall,
    input wire logic [1:0]  read_data_valid_flag,
    input wire logic [1:0]  sync_clock_polarity,
    input wire logic [1:0]  read_strobe_shifted,
    input wire logic [1:0]  write_strobe_shifted
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic [1:0] pol_d;
    // Short aliases and the bits of polarity that just changed.
    wire [1:0] vld = read_data_valid_flag;
    wire [1:0] pol = sync_clock_polarity;
    wire [1:0] rss = read_strobe_shifted;
    wire [1:0] chg = pol ^ pol_d;
    // Keeps last cycle's polarity.
    always @(posedge ref_clk) begin
        pol_d <= pol;
    end

    chk_valid_pulse: assert property (|vld |=> (vld & $past(vld)) == 2'h0)
        else $error("valid flag held longer than one cycle");
    chk_plain_quiet: assert property (!ddr_mode [*4] |-> vld == 2'h0)
        else $error("valid flag outside DDR mode");
    chk_data_hold: assert property (ddr_mode && $past(ddr_mode) && vld == 2'h0
        |-> $stable(rd_data_rise) && $stable(rd_data_fall))
        else $error("read data changed without valid");
    chk_pol_hold: assert property (!read_en && !$past(read_en)
        && !$past(read_en, 2) |-> $stable(pol))
        else $error("polarity changed between reads");
    chk_pol_on_rise: assert property (chg != 2'h0 |-> (rss & chg) == chg)
        else $error("polarity changed without a strobe rise");
    chk_strobe_lag: assert property (dll_cal == 6'h04 && $past(dll_cal, 4) == 6'h04
        |-> rss == $past(write_strobe_shifted, 2))
        else $error("strobe taps not two cycles apart");
    chk_valid_fall: assert property (vld[0] |-> !rss[0] && ($past(rss[0])
        || $past(rss[0], 2) || $past(rss[0], 3) || $past(rss[0], 4)))
        else $error("valid not just after a strobe fall");
    chk_idle_quiet: assert property (!read_en [*6] |-> vld == 2'h0)
        else $error("valid flag with no read armed");

    cover property (vld[0]);
    cover property (chg[0] && pol[0]);
    cover property (chg[0] && !pol[0]);
endmodule // ddrrc_checker

bind ddrrc_top ddrrc_checker i_chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .ddr_mode(ddr_mode), .read_en(read_en), .dll_cal(dll_cal),
    .rd_data_rise(rd_data_rise), .rd_data_fall(rd_data_fall),
    .read_data_valid_flag(read_data_valid_flag),
    .sync_clock_polarity(sync_clock_polarity),
    .read_strobe_shifted(read_strobe_shifted),
    .write_strobe_shifted(write_strobe_shifted));
`default_nettype wire

// >>> testbench/ddrrc_mem_model.sv
// Behavioural DDR memory that drives the strobes and data of a read.
// Assumes the bench calls its tasks; both groups share one strobe timing.
`timescale 1ns/1ps
`default_nettype none
module ddrrc_mem_model (
    output var logic [1:0]  strobe,
    output var logic [15:0] dq
);
    // Idle strobe rests on termination, seen as high.
    initial begin
        strobe = 2'h3;
        dq     = 16'h5a5a;
    end

    // Low preamble, then a rise and a fall beat per pair, then release.
    task automatic burst(input logic [15:0] r[$], input logic [15:0] f[$]);
        strobe = 2'h0;
        dq     = ~dq;
        #80;
        foreach (r[i]) begin
            strobe = 2'h3;
            dq     = r[i];
            #40;
            strobe = 2'h0;
            dq     = f[i];
            #40;
        end
        strobe = 2'h3;
        dq     = ~dq;
    endtask

    // Parks a steady word on the data pins.
    task automatic hold_word(input logic [15:0] w);
        dq = w;
    endtask
endmodule // ddrrc_mem_model
`default_nettype wire

// >>> verilog/ddrrc_defs.vh
// Constants for the read capture and clock transfer block of a DDR port.
// Assumes inclusion by bare name from the files under verilog/.
// Operation
// - In DDR memory mode each data bit is captured twice, on the rising and falling edge of the shifted read strobe.
// - Both captured streams are re-registered in the system clock domain before they reach the core.
// - The polarity signal chooses the system clock phase on which the synchronizing registers load.
// - Only the right-edge input block has DDR memory mode, on top of the plain capture mode.
// - DDR support is two groups of 14 or 12 cells, together giving a data width of up to 16 bits.
// - One cell per group holds the strobe control element that makes and distributes the group's strobes and flags.
// - The shifted read and write strobes are both derived from the incoming data strobe.
// - The polarity is worked out again at the start of every read, not fixed once.
// - The first strobe rising edge after the preamble is detected and sets the polarity signal.
// - The strobe delay is trimmed for process, voltage and temperature by a 6-bit code from a DLL.
`ifndef DDRRC_DEFS_VH
`define DDRRC_DEFS_VH

// Data path geometry.
`define DDRRC_GROUPS      2
`define DDRRC_GROUP_BITS  8
`define DDRRC_DQ_WIDTH    16
`define DDRRC_CELLS_BIG   14
`define DDRRC_CELLS_SMALL 12

// Strobe delay line and its calibration code.
`define DDRRC_CAL_WIDTH   6
`define DDRRC_DLY_TAPS    64

// Reset values.
`define DDRRC_CAL_RESET   6'h04
`define DDRRC_BIT_RESET   1'b0
// The strobe rests high on its termination, so its path resets high too.
`define DDRRC_STROBE_IDLE 1'b1

`endif

// >>> verilog/ddrrc_strobe_ctl.v
// Strobe control element of one cell group: sync, delay, edge and polarity.
// Assumes ref_clk at 200 MHz and a strobe pin that is not synchronous to it.
`timescale 1ns/1ps
`default_nettype none
`include "ddrrc_defs.vh"

module ddrrc_strobe_ctl (
    input  wire                       ref_clk,
    input  wire                       reset_n,
    input  wire                       strobe_pin,
    input  wire [`DDRRC_CAL_WIDTH-1:0] cal_code,
    input  wire                       read_en,
    input  wire                       phase,
    output reg                        read_strobe_shifted,
    output reg                        write_strobe_shifted,
    output reg                        rise_pulse,
    output reg                        fall_pulse,
    output reg                        sync_clock_polarity,
    output reg                        read_active
);

    localparam [3:0] ST_IDLE   = 4'h1;
    localparam [3:0] ST_ARMED  = 4'h2;
    localparam [3:0] ST_PRE    = 4'h4;
    localparam [3:0] ST_ACTIVE = 4'h8;

    reg                          strobe_s1_reg;
    reg                          strobe_s2_reg;
    reg [`DDRRC_DLY_TAPS-1:0]    dly_reg;
    reg [3:0]                    state_reg;
    reg [3:0]                    state_next;
    wire                         rs_tap;
    wire                         ws_tap;
    wire                         rs_rise;
    wire                         rs_fall;

    ////////////////////////////////////////////////////////////////////////
    // Both strobes come from taps of one delay line on the strobe input.
    assign rs_tap  = dly_reg[cal_code];
    assign ws_tap  = dly_reg[cal_code >> 1];
    assign rs_rise = rs_tap & ~read_strobe_shifted;
    assign rs_fall = ~rs_tap & read_strobe_shifted;

    // Two-flop synchroniser, then the delay line and strobe outputs.
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            // Reset to the idle strobe level, so that no false preamble or
            // rise is seen while the delay line refills after reset.
            strobe_s1_reg        <= `DDRRC_STROBE_IDLE;
            strobe_s2_reg        <= `DDRRC_STROBE_IDLE;
            dly_reg              <= {`DDRRC_DLY_TAPS{`DDRRC_STROBE_IDLE}};
            read_strobe_shifted  <= `DDRRC_STROBE_IDLE;
            write_strobe_shifted <= `DDRRC_STROBE_IDLE;
        end else begin
            strobe_s1_reg        <= strobe_pin;
            strobe_s2_reg        <= strobe_s1_reg;
            dly_reg <= {dly_reg[`DDRRC_DLY_TAPS-2:0], strobe_s2_reg};
            read_strobe_shifted  <= rs_tap;
            write_strobe_shifted <= ws_tap;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read sequence: armed, wait for the driven-low preamble, first rise.
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (read_en)
                    state_next = ST_ARMED;
            end
            ST_ARMED: begin
                if (!read_en)
                    state_next = ST_IDLE;
                else if (!rs_tap)
                    state_next = ST_PRE;
            end
            ST_PRE: begin
                if (!read_en)
                    state_next = ST_IDLE;
                else if (rs_rise)
                    state_next = ST_ACTIVE;
            end
            ST_ACTIVE: begin
                if (!read_en)
                    state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // State, polarity choice and the capture pulses for the group.
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            state_reg           <= ST_IDLE;
            sync_clock_polarity <= `DDRRC_BIT_RESET;
            rise_pulse          <= `DDRRC_BIT_RESET;
            fall_pulse          <= `DDRRC_BIT_RESET;
            read_active         <= `DDRRC_BIT_RESET;
        end else begin
            state_reg <= state_next;
            // The polarity changes only on the first post-preamble rise.
            if (state_reg == ST_PRE && rs_rise && read_en)
                sync_clock_polarity <= ~phase;
            rise_pulse  <= rs_rise & (state_next == ST_ACTIVE);
            fall_pulse  <= rs_fall & (state_reg == ST_ACTIVE) & read_en;
            read_active <= (state_next == ST_ACTIVE);
        end
    end

endmodule // ddrrc_strobe_ctl

`default_nettype wire

// >>> verilog/ddrrc_top.v
// Read capture and system clock transfer for a 16-bit DDR read port.
// Assumes all pins are asynchronous to ref_clk; read_en and ddr_mode come
// from core logic on ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "ddrrc_defs.vh"

module ddrrc_top (
    input  wire                         ref_clk,
    input  wire                         reset_n,
    input  wire                         ddr_mode,
    input  wire                         read_en,
    input  wire [`DDRRC_DQ_WIDTH-1:0]   dq_pin,
    input  wire [`DDRRC_GROUPS-1:0]     strobe_pin,
    input  wire [`DDRRC_CAL_WIDTH-1:0]  dll_cal,
    output reg  [`DDRRC_DQ_WIDTH-1:0]   rd_data_rise,
    output reg  [`DDRRC_DQ_WIDTH-1:0]   rd_data_fall,
    output reg  [`DDRRC_GROUPS-1:0]     read_data_valid_flag,
    output wire [`DDRRC_GROUPS-1:0]     sync_clock_polarity,
    output wire [`DDRRC_GROUPS-1:0]     read_strobe_shifted,
    output wire [`DDRRC_GROUPS-1:0]     write_strobe_shifted
);

    reg  [`DDRRC_CAL_WIDTH-1:0]  cal_s1_reg;
    reg  [`DDRRC_CAL_WIDTH-1:0]  cal_s2_reg;
    reg  [`DDRRC_DQ_WIDTH-1:0]   dq_s1_reg;
    reg  [`DDRRC_DQ_WIDTH-1:0]   dq_s2_reg;
    reg  [`DDRRC_DQ_WIDTH-1:0]   cap_rise_reg;
    reg  [`DDRRC_DQ_WIDTH-1:0]   cap_fall_reg;
    reg  [`DDRRC_GROUPS-1:0]     pending_reg;
    reg                          phase_reg;
    wire [`DDRRC_GROUPS-1:0]     rise_pulse;
    wire [`DDRRC_GROUPS-1:0]     fall_pulse;
    wire [`DDRRC_GROUPS-1:0]     read_active;

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers for the data pins and the DLL code, and the
    // two-phase system clock marker that stands in for the opposite edge.
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            cal_s1_reg <= `DDRRC_CAL_RESET;
            cal_s2_reg <= `DDRRC_CAL_RESET;
            dq_s1_reg  <= {`DDRRC_DQ_WIDTH{1'b0}};
            dq_s2_reg  <= {`DDRRC_DQ_WIDTH{1'b0}};
            phase_reg  <= `DDRRC_BIT_RESET;
        end else begin
            cal_s1_reg <= dll_cal;
            cal_s2_reg <= cal_s1_reg;
            dq_s1_reg  <= dq_pin;
            dq_s2_reg  <= dq_s1_reg;
            phase_reg  <= ~phase_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One strobe control element and one data slice per cell group.
    genvar g;
    generate
        for (g = 0; g < `DDRRC_GROUPS; g = g + 1) begin : grp
            wire                          load;
            wire [`DDRRC_GROUP_BITS-1:0]  dq_g;

            assign dq_g = dq_s2_reg[g*`DDRRC_GROUP_BITS +: `DDRRC_GROUP_BITS];
            // Sync registers load only on the phase the polarity selects.
            assign load = (phase_reg == sync_clock_polarity[g]);

            // Control element shared by every data cell of the group.
            ddrrc_strobe_ctl u_ctl (
                .ref_clk              (ref_clk),
                .reset_n              (reset_n),
                .strobe_pin           (strobe_pin[g]),
                .cal_code             (cal_s2_reg),
                .read_en              (read_en & ddr_mode),
                .phase                (phase_reg),
                .read_strobe_shifted  (read_strobe_shifted[g]),
                .write_strobe_shifted (write_strobe_shifted[g]),
                .rise_pulse           (rise_pulse[g]),
                .fall_pulse           (fall_pulse[g]),
                .sync_clock_polarity  (sync_clock_polarity[g]),
                .read_active          (read_active[g])
            );

            // Capture on both strobe edges, then transfer to ref_clk.
            always @(posedge ref_clk) begin
                if (!reset_n) begin
                    cap_rise_reg[g*`DDRRC_GROUP_BITS +: `DDRRC_GROUP_BITS]
                        <= {`DDRRC_GROUP_BITS{1'b0}};
                    cap_fall_reg[g*`DDRRC_GROUP_BITS +: `DDRRC_GROUP_BITS]
                        <= {`DDRRC_GROUP_BITS{1'b0}};
                    rd_data_rise[g*`DDRRC_GROUP_BITS +: `DDRRC_GROUP_BITS]
                        <= {`DDRRC_GROUP_BITS{1'b0}};
                    rd_data_fall[g*`DDRRC_GROUP_BITS +: `DDRRC_GROUP_BITS]
                        <= {`DDRRC_GROUP_BITS{1'b0}};
                    pending_reg[g]          <= `DDRRC_BIT_RESET;
                    read_data_valid_flag[g] <= `DDRRC_BIT_RESET;
                end else if (!ddr_mode) begin
                    // Plain capture: one register per cycle, no strobe.
                    rd_data_rise[g*`DDRRC_GROUP_BITS +: `DDRRC_GROUP_BITS]
                        <= dq_g;
                    pending_reg[g]          <= `DDRRC_BIT_RESET;
                    read_data_valid_flag[g] <= `DDRRC_BIT_RESET;
                end else begin
                    if (rise_pulse[g])
                        cap_rise_reg[g*`DDRRC_GROUP_BITS +: `DDRRC_GROUP_BITS]
                            <= dq_g;
                    if (fall_pulse[g])
                        cap_fall_reg[g*`DDRRC_GROUP_BITS +: `DDRRC_GROUP_BITS]
                            <= dq_g;
                    // A pair completes on the fall; a new fall wins a clear.
                    if (fall_pulse[g])
                        pending_reg[g] <= 1'b1;
                    else if (load)
                        pending_reg[g] <= 1'b0;
                    read_data_valid_flag[g] <= load & pending_reg[g];
                    if (load && pending_reg[g]) begin
                        rd_data_rise[g*`DDRRC_GROUP_BITS +: `DDRRC_GROUP_BITS]
                            <= cap_rise_reg[g*`DDRRC_GROUP_BITS +:
                                            `DDRRC_GROUP_BITS];
                        rd_data_fall[g*`DDRRC_GROUP_BITS +: `DDRRC_GROUP_BITS]
                            <= cap_fall_reg[g*`DDRRC_GROUP_BITS +:
                                            `DDRRC_GROUP_BITS];
                    end
                end
            end
        end
    endgenerate

endmodule // ddrrc_top

`default_nettype wire
